// [core/button_pkg.sv]
// constants, register map and carrier types of the button detector
package button_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_IRQ_POL  = 8'h11;
    localparam logic [7:0] ADDR_SLOW_INC = 8'h13;
    localparam logic [7:0] ADDR_FAST_INC = 8'h15;
    localparam logic [7:0] ADDR_HOLD_MAX = 8'h16;
    localparam logic [7:0] ADDR_MARGIN   = 8'h18;
    localparam logic [7:0] ADDR_TWIST    = 8'h19;
    localparam logic [7:0] ADDR_CM_BEND  = 8'h1A;
    localparam logic [7:0] ADDR_SCALER   = 8'h1E;
    localparam logic [7:0] ADDR_SPEED0   = 8'h25;
    localparam logic [7:0] ADDR_SPEED12  = 8'h28;
    localparam logic [7:0] ADDR_SPEED3   = 8'h2B;

    // ---------------------------------------------------------------
    // reset values and field positions
    // ---------------------------------------------------------------
    localparam logic [7:0] MARGIN_RST    = 8'h20;
    localparam logic [7:0] ZERO_RST      = 8'h00;
    localparam logic [7:0] INC_IDX_RST   = 8'h03;
    localparam int         STAT_PRESS    = 0;
    localparam int         STAT_READY    = 1;
    localparam int         STAT_ERR_LSB  = 4;
    localparam int         TWIST_EN      = 7;
    localparam int         IDX_W         = 3;

    // ---------------------------------------------------------------
    // thresholds and tracking arithmetic, steps in 1/72 count units
    // ---------------------------------------------------------------
    localparam int          THRESH_NOM   = 128;
    localparam logic [15:0] STEP_DEN     = 16'h0048;
    localparam logic [15:0] LP_SCALE     = 16'h0008;
    localparam logic [15:0] CONT_STEP    = 16'h0048;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } reg_req_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  chan;
        logic [15:0] count;
    } window_t;

endpackage

// [core/button_detector.sv]
// per-channel threshold, baseline tracking, rejection filters and interrupt reporting
`timescale 1ns/100ps
`default_nettype none
module button_detector #(
    parameter int NUM_CH = 4,
    parameter int RAW_W  = 16
) (
    // clock and reset
    input  wire  logic                ref_clk,
    input  wire  logic                reset_n,
    input  wire  logic                ce,
    // register access
    input  wire  button_pkg::reg_req_t reg_req,
    output logic [7:0]                reg_rdata,
    // conversion front end
    input  wire  button_pkg::window_t window,
    input  wire  logic                cycle_done,
    input  wire  logic [3:0]          error_event,
    // mode straps
    input  wire  logic                power_level_pin,
    input  wire  logic                raw_data_mode,
    input  wire  logic                continuous_sampling_bit,
    // outputs
    output logic [NUM_CH-1:0]         button_output,
    output logic                      irq_pin,
    output logic [7:0]                count_scaler
);
    import button_pkg::*;

    localparam int RW = RAW_W + 1;

    if (NUM_CH != 4 || RAW_W != 16) begin : g_check
        $error("button_detector: NUM_CH must be 4 and RAW_W 16");
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] status_reg;
    logic [7:0] irq_pol_reg;
    logic [7:0] slow_inc_reg;
    logic [7:0] fast_inc_reg;
    logic [7:0] hold_max_reg;
    logic [7:0] margin_reg;
    logic [7:0] twist_reg;
    logic [7:0] cm_bend_reg;
    logic [7:0] speed0_reg;
    logic [7:0] speed12_reg;
    logic [7:0] speed3_reg;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            irq_pol_reg  <= ZERO_RST;
            slow_inc_reg <= INC_IDX_RST;
            fast_inc_reg <= INC_IDX_RST;
            hold_max_reg <= ZERO_RST;
            margin_reg   <= MARGIN_RST;
            twist_reg    <= ZERO_RST;
            cm_bend_reg  <= ZERO_RST;
            count_scaler <= ZERO_RST;
            speed0_reg   <= ZERO_RST;
            speed12_reg  <= ZERO_RST;
            speed3_reg   <= ZERO_RST;
        end else if (ce && reg_req.wr) begin
            unique case (reg_req.addr)
                ADDR_IRQ_POL:  irq_pol_reg  <= reg_req.wdata;
                ADDR_SLOW_INC: slow_inc_reg <= reg_req.wdata;
                ADDR_FAST_INC: fast_inc_reg <= reg_req.wdata;
                ADDR_HOLD_MAX: hold_max_reg <= reg_req.wdata;
                ADDR_MARGIN:   margin_reg   <= reg_req.wdata;
                ADDR_TWIST:    twist_reg    <= reg_req.wdata;
                ADDR_CM_BEND:  cm_bend_reg  <= reg_req.wdata;
                ADDR_SCALER:   count_scaler <= reg_req.wdata;
                ADDR_SPEED0:   speed0_reg   <= reg_req.wdata;
                ADDR_SPEED12:  speed12_reg  <= reg_req.wdata;
                ADDR_SPEED3:   speed3_reg   <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= ZERO_RST;
        end else if (ce) begin
            if (reg_req.rd) begin
                unique case (reg_req.addr)
                    ADDR_STATUS:   reg_rdata <= status_reg;
                    ADDR_IRQ_POL:  reg_rdata <= irq_pol_reg;
                    ADDR_SLOW_INC: reg_rdata <= slow_inc_reg;
                    ADDR_FAST_INC: reg_rdata <= fast_inc_reg;
                    ADDR_HOLD_MAX: reg_rdata <= hold_max_reg;
                    ADDR_MARGIN:   reg_rdata <= margin_reg;
                    ADDR_TWIST:    reg_rdata <= twist_reg;
                    ADDR_CM_BEND:  reg_rdata <= cm_bend_reg;
                    ADDR_SCALER:   reg_rdata <= count_scaler;
                    ADDR_SPEED0:   reg_rdata <= speed0_reg;
                    ADDR_SPEED12:  reg_rdata <= speed12_reg;
                    ADDR_SPEED3:   reg_rdata <= speed3_reg;
                    default:       reg_rdata <= ZERO_RST;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // per-channel state
    // ---------------------------------------------------------------
    logic [RAW_W-1:0]   base_reg   [NUM_CH];
    logic [6:0]         frac_reg   [NUM_CH];
    logic signed [RW-1:0] result_reg [NUM_CH];
    logic [NUM_CH-1:0]  seeded_reg;

    logic                fire;
    logic [1:0]          ch;
    logic signed [RW-1:0] res_new;
    logic signed [RW-1:0] th_on;
    logic signed [RW-1:0] th_off;
    logic signed [RW-1:0] twist_lim;
    logic [1:0]          negative_speedup_code;

    assign fire      = ce && window.valid;
    assign ch        = window.chan;
    assign res_new   = $signed({1'b0, window.count}) - $signed({1'b0, base_reg[ch]});
    assign th_on     = RW'(THRESH_NOM) + RW'(margin_reg);
    assign th_off    = RW'(THRESH_NOM) - RW'(margin_reg);
    assign twist_lim = -$signed(RW'(twist_reg[6:0]));

    always_comb begin
        unique case (ch)
            2'd0:    negative_speedup_code = speed0_reg[1:0];
            2'd1:    negative_speedup_code = speed12_reg[1:0];
            2'd2:    negative_speedup_code = speed12_reg[3:2];
            default: negative_speedup_code = speed3_reg[1:0];
        endcase
    end

    // ---------------------------------------------------------------
    // filter views over all channels, current one freshly updated
    // ---------------------------------------------------------------
    logic [NUM_CH-1:0] above;
    logic [NUM_CH-1:0] beats_me;
    logic [NUM_CH-1:0] twisted;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_view
        logic signed [RW-1:0] res_i;
        assign res_i       = (ch == 2'(i)) ? res_new : result_reg[i];
        assign above[i]    = res_i >= th_on;
        assign twisted[i]  = res_i < twist_lim;
        assign beats_me[i] = (ch != 2'(i)) && hold_max_reg[4+i] && above[i]
                             && (res_i > res_new);
    end

    logic [3:0] cm_hits;
    logic       twist_block;
    logic       common_block;
    logic       deform_block;
    logic       group_lose;
    logic       press_ok;
    logic       stay_on;
    logic       out_bit_next;

    assign cm_hits      = above & cm_bend_reg[3:0];
    assign twist_block  = twist_reg[TWIST_EN] && (|twisted);
    assign common_block = cm_bend_reg[ch] && (|(cm_hits & (cm_hits - 4'h1)));
    assign deform_block = cm_bend_reg[4+ch]
                          && (|(button_output & ~(4'h1 << ch)));
    assign group_lose   = hold_max_reg[4+ch] && (|beats_me);
    assign press_ok     = (res_new >= th_on) && !twist_block && !common_block
                          && !deform_block && !group_lose;
    assign stay_on      = res_new > th_off;
    assign out_bit_next = !raw_data_mode
                          && (button_output[ch] ? stay_on : press_ok);

    // ---------------------------------------------------------------
    // baseline step, kept as whole counts plus 1/72 residue
    // ---------------------------------------------------------------
    logic [15:0] step;
    logic [15:0] step_q;
    logic [6:0]  step_r;
    logic [7:0]  frac_up;
    logic        hold_now;
    logic        track_en;

    always_comb begin
        if (continuous_sampling_bit) begin
            step = CONT_STEP;
        end else if (power_level_pin) begin
            step = 16'h0001 << fast_inc_reg[IDX_W-1:0];
        end else begin
            step = LP_SCALE << slow_inc_reg[IDX_W-1:0];
        end
        if (res_new < 0) begin
            unique case (negative_speedup_code)
                2'b00: step = step;
                2'b01: step = step << 2;
                2'b10: step = step << 3;
                2'b11: step = step << 4;
            endcase
        end
    end

    assign step_q   = step / STEP_DEN;
    assign step_r   = 7'(step % STEP_DEN);
    assign frac_up  = {1'b0, frac_reg[ch]} + {1'b0, step_r};
    assign hold_now = hold_max_reg[ch] && button_output[ch];
    assign track_en = !raw_data_mode && !hold_now;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            seeded_reg <= '0;
            for (int k = 0; k < NUM_CH; k++) begin
                base_reg[k]   <= '0;
                frac_reg[k]   <= '0;
                result_reg[k] <= '0;
            end
        end else if (fire) begin
            seeded_reg[ch] <= 1'b1;
            if (!seeded_reg[ch]) begin
                base_reg[ch]   <= window.count;
                result_reg[ch] <= '0;
            end else begin
                result_reg[ch] <= res_new;
                if (track_en && res_new > 0) begin
                    if (frac_up >= 8'(STEP_DEN)) begin
                        frac_reg[ch] <= 7'(frac_up - 8'(STEP_DEN));
                        base_reg[ch] <= base_reg[ch] + RAW_W'(step_q) + 1'b1;
                    end else begin
                        frac_reg[ch] <= frac_up[6:0];
                        base_reg[ch] <= base_reg[ch] + RAW_W'(step_q);
                    end
                end else if (track_en && res_new < 0) begin
                    if (frac_reg[ch] >= step_r) begin
                        frac_reg[ch] <= frac_reg[ch] - step_r;
                        base_reg[ch] <= base_reg[ch] - RAW_W'(step_q);
                    end else begin
                        frac_reg[ch] <= 7'(8'(frac_reg[ch]) + 8'(STEP_DEN) - 8'(step_r));
                        base_reg[ch] <= base_reg[ch] - RAW_W'(step_q) - 1'b1;
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // button outputs, status and interrupt
    // ---------------------------------------------------------------
    logic [NUM_CH-1:0] button_next;
    logic [7:0]        status_next;
    logic              irq_act;

    always_comb begin
        button_next = raw_data_mode ? '0 : button_output;
        if (fire && seeded_reg[ch]) begin
            button_next[ch] = out_bit_next;
        end
    end

    always_comb begin
        status_next = status_reg;
        if (ce && reg_req.rd && reg_req.addr == ADDR_STATUS) begin
            status_next = ZERO_RST;
        end
        if (|(button_next & ~button_output)) begin
            status_next[STAT_PRESS] = 1'b1;
        end
        if (raw_data_mode && cycle_done) begin
            status_next[STAT_READY] = 1'b1;
        end
        status_next[STAT_ERR_LSB +: 4] = status_next[STAT_ERR_LSB +: 4] | error_event;
    end

    assign irq_act = (|button_next) || (|status_next[STAT_ERR_LSB +: 4])
                     || status_next[STAT_READY];

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            button_output <= '0;
            status_reg    <= ZERO_RST;
            irq_pin       <= 1'b1;
        end else if (ce) begin
            button_output <= button_next;
            status_reg    <= status_next;
            irq_pin       <= irq_pol_reg[0] ? irq_act : !irq_act;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [1:0] ch_d;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ch_d <= 2'd0;
        end else if (ce) begin
            ch_d <= ch;
        end
    end

    a_press_below_thr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && !button_output[ch] && res_new < th_on) |=> !button_output[ch_d])
        else $error("press reported below on threshold");

    a_release_at_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && seeded_reg[ch] && button_output[ch] && res_new <= th_off)
        |=> !button_output[ch_d])
        else $error("button not released at off threshold");

    a_raw_no_track: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && raw_data_mode && seeded_reg[ch]) |=> (base_reg[ch_d] == $past(base_reg[ch])))
        else $error("baseline moved in raw data mode");

    a_hold_freezes: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && hold_max_reg[ch] && button_output[ch] && seeded_reg[ch])
        |=> (base_reg[ch_d] == $past(base_reg[ch])))
        else $error("baseline moved while held");

    a_twist_blocks: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && twist_block && !button_output[ch]) |=> !button_output[ch_d])
        else $error("press passed during twist");

    a_group_loser: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && group_lose && !button_output[ch]) |=> !button_output[ch_d])
        else $error("weaker group press reported");

    a_irq_while_down: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ((|button_output) && $stable(irq_pol_reg)) |-> (irq_pin == irq_pol_reg[0]))
        else $error("interrupt idle while button pressed");

    a_press_seen_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ce && |(button_output & ~$past(button_output))) |-> status_reg[STAT_PRESS])
        else $error("press seen flag missing");

    a_error_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ce && (|error_event)) |=> (irq_pin == irq_pol_reg[0])
        && (|status_reg[STAT_ERR_LSB +: 4]))
        else $error("error not reported");

    a_shared_blocks: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && common_block && !button_output[ch]) |=> !button_output[ch_d])
        else $error("shared response reported as press");

    a_bend_blocks: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && deform_block && !button_output[ch]) |=> !button_output[ch_d])
        else $error("press passed beside asserted button");

    a_press_taken: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && seeded_reg[ch] && !raw_data_mode && !button_output[ch] && press_ok)
        |=> button_output[ch_d])
        else $error("qualified press not reported");

    a_raw_outputs_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ce && raw_data_mode) |=> (button_output == '0))
        else $error("button output set in raw data mode");

    a_ready_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ce && raw_data_mode && cycle_done)
        |=> (irq_pin == $past(irq_pol_reg[0])) && status_reg[STAT_READY])
        else $error("raw data ready not reported");

    a_flag_cleared: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ce && reg_req.rd && reg_req.addr == ADDR_STATUS && !(|(button_next & ~button_output)))
        |=> !status_reg[STAT_PRESS])
        else $error("press seen flag survived status read");

    a_fixed_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (fire && seeded_reg[ch] && continuous_sampling_bit && track_en && res_new > 0)
        |=> (base_reg[ch_d] == $past(base_reg[ch]) + 1'b1))
        else $error("fixed baseline step not applied");

endmodule // button_detector
`default_nettype wire

// [tb/host_agent.sv]
// host-side register agent driving the detector's register port
`timescale 1ns/100ps
`default_nettype none
module host_agent (
    // clock
    input  wire logic                 ref_clk,
    // register port
    output var  button_pkg::reg_req_t reg_req,
    input  wire logic [7:0]           reg_rdata
);
    import button_pkg::*;

    initial reg_req = '0;

    // one-cycle write strobe launched off the falling edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_req = {1'b1, 1'b0, a, d};
        @(negedge ref_clk);
        reg_req = '0;
    endtask

    // read data is registered, so it is picked up one cycle after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_req = {1'b0, 1'b1, a, 8'h00};
        @(negedge ref_clk);
        reg_req = '0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
endmodule // host_agent
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the button detector
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import button_pkg::*;
    logic       ref_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       ce = 1'b1;
    reg_req_t   reg_req;
    window_t    window = '0;
    logic       cycle_done = 1'b0;
    logic [3:0] error_event = 4'h0;
    logic       power_level_pin = 1'b1;
    logic       raw_data_mode = 1'b0;
    logic       continuous_sampling_bit = 1'b0;
    logic [3:0] button_output;
    logic       irq_pin;
    logic [7:0] reg_rdata;
    logic [7:0] count_scaler;
    logic [7:0] rd;
    int         mismatches = 0;
    int         compares = 0;
    int         n;

    always #20 ref_clk = ~ref_clk;

    host_agent host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

    button_detector DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .window(window), .cycle_done(cycle_done),
        .error_event(error_event), .power_level_pin(power_level_pin),
        .raw_data_mode(raw_data_mode), .continuous_sampling_bit(continuous_sampling_bit),
        .button_output(button_output), .irq_pin(irq_pin), .count_scaler(count_scaler)
    );

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic do_reset;
        @(negedge ref_clk);
        reset_n = 1'b0;
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
    endtask

    // one window pulse, then one more cycle so the registered answer has landed
    task automatic win(input logic [1:0] c, input logic [15:0] v);
        @(negedge ref_clk);
        window = {1'b1, c, v};
        @(negedge ref_clk);
        window.valid = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic conclude;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs;
        do_reset;
        chk({4'h0, button_output}, 8'h00, "outputs after reset");
        chk({7'h0, irq_pin}, 8'h01, "irq idle after reset");
        host.read_reg(ADDR_MARGIN, rd);
        chk(rd, 8'h20, "margin default");
        host.write_reg(ADDR_SCALER, 8'h5A);
        chk(count_scaler, 8'h5A, "scaler register");
        ce = 1'b0;
        host.write_reg(ADDR_SCALER, 8'hA5);
        ce = 1'b1;
        chk(count_scaler, 8'h5A, "write ignored while disabled");
        host.read_reg(8'h7F, rd);
        chk(rd, 8'h00, "unmapped read");
        for (int i = 0; i < 4; i++) begin
            host.write_reg(ADDR_SPEED0, 8'(i));
            host.read_reg(ADDR_SPEED0, rd);
            chk(rd, 8'(i), "speed-up code readback");
        end
    endtask

    task automatic t_threshold;
        do_reset;
        win(0, 16'd1000);
        win(0, 16'd1159);
        chk({4'h0, button_output}, 8'h00, "below on threshold");
        win(0, 16'd1162);
        chk({4'h0, button_output}, 8'h01, "press at on threshold");
        chk({7'h0, irq_pin}, 8'h00, "irq on press");
        win(0, 16'd1098);
        chk({4'h0, button_output}, 8'h01, "hysteresis hold");
        host.read_reg(ADDR_STATUS, rd);
        chk(rd, 8'h01, "press-seen flag");
        host.read_reg(ADDR_STATUS, rd);
        chk(rd, 8'h00, "flag cleared by read");
        win(0, 16'd1090);
        chk({4'h0, button_output}, 8'h00, "release");
        chk({7'h0, irq_pin}, 8'h01, "irq off after release");
    endtask

    task automatic t_margin_multi;
        do_reset;
        host.write_reg(ADDR_MARGIN, 8'h10);
        win(1, 16'd2000);
        win(0, 16'd3000);
        win(1, 16'd2143);
        chk({4'h0, button_output}, 8'h00, "below programmed on level");
        win(1, 16'd2146);
        chk({4'h0, button_output}, 8'h02, "press with margin 16");
        win(0, 16'd3150);
        chk({4'h0, button_output}, 8'h03, "second button");
        win(1, 16'd2108);
        chk({4'h0, button_output}, 8'h01, "release with margin 16");
        chk({7'h0, irq_pin}, 8'h00, "irq held while any pressed");
    endtask

    task automatic t_filters;
        do_reset;
        host.write_reg(ADDR_TWIST, 8'h94);
        win(0, 16'd1000);
        win(1, 16'd1000);
        win(1, 16'd970);
        win(0, 16'd1170);
        chk({4'h0, button_output}, 8'h00, "twist blocks press");
        do_reset;
        host.write_reg(ADDR_HOLD_MAX, 8'h30);
        win(0, 16'd1000);
        win(1, 16'd1000);
        win(1, 16'd1200);
        win(0, 16'd1180);
        chk({4'h0, button_output}, 8'h02, "strongest press wins");
        for (int g = 0; g < 2; g++) begin
            do_reset;
            host.write_reg(ADDR_CM_BEND, g ? 8'h10 : 8'h03);
            win(0, 16'd1000);
            win(1, 16'd1000);
            win(1, 16'd1170);
            win(0, 16'd1170);
            chk({4'h0, button_output}, 8'h02, "shared or bend press blocked");
        end
        for (int f = 0; f < 2; f++) begin
            do_reset;
            host.write_reg(ADDR_SPEED0, f ? 8'h03 : 8'h00);
            win(0, 16'd1000);
            repeat (9) win(0, 16'd900);
            win(0, 16'd1144);
            chk({4'h0, button_output}, 8'(f), "speed-up pulls baseline");
        end
    endtask

    task automatic t_error_raw;
        do_reset;
        host.write_reg(ADDR_IRQ_POL, 8'h01);
        @(negedge ref_clk);
        chk({7'h0, irq_pin}, 8'h00, "inverted idle polarity");
        host.write_reg(ADDR_IRQ_POL, 8'h00);
        @(negedge ref_clk);
        error_event = 4'h4;
        @(negedge ref_clk);
        error_event = 4'h0;
        @(negedge ref_clk);
        chk({7'h0, irq_pin}, 8'h00, "irq on error");
        host.read_reg(ADDR_STATUS, rd);
        chk(rd, 8'h40, "error cause recorded");
        @(negedge ref_clk);
        chk({7'h0, irq_pin}, 8'h01, "irq cleared with status");
        raw_data_mode = 1'b1;
        win(0, 16'd1000);
        win(0, 16'd1300);
        chk({4'h0, button_output}, 8'h00, "outputs unused in raw mode");
        cycle_done = 1'b1;
        @(negedge ref_clk);
        cycle_done = 1'b0;
        @(negedge ref_clk);
        chk({7'h0, irq_pin}, 8'h00, "raw data ready irq");
        host.read_reg(ADDR_STATUS, rd);
        chk(rd, 8'h02, "ready flag");
        raw_data_mode = 1'b0;
    endtask

    // constant press: counts windows until tracking drags the result to release
    task automatic trk(input logic cont, input logic pl, input logic hold, output int cnt);
        do_reset;
        power_level_pin = pl;
        continuous_sampling_bit = cont;
        if (hold)
            host.write_reg(ADDR_HOLD_MAX, 8'h01);
        win(0, 16'd1000);
        for (cnt = 1; cnt < 120; cnt++) begin
            win(0, 16'd1165);
            if (cnt > 1 && button_output[0] === 1'b0)
                break;
        end
        continuous_sampling_bit = 1'b0;
        power_level_pin = 1'b1;
    endtask

    task automatic t_tracking;
        trk(1'b1, 1'b1, 1'b0, n);
        chk(8'(n >= 67 && n <= 73), 8'h01, "fixed step release");
        trk(1'b0, 1'b0, 1'b0, n);
        chk(8'(n >= 76 && n <= 82), 8'h01, "low power step release");
        trk(1'b0, 1'b1, 1'b0, n);
        chk(8'(n), 8'd120, "normal power slow step");
        trk(1'b1, 1'b1, 1'b1, n);
        chk(8'(n), 8'd120, "hold freezes tracking");
    endtask

    initial begin
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        t_regs;
        t_threshold;
        t_margin_multi;
        t_filters;
        t_error_raw;
        t_tracking;
        conclude;
    end

    // watchdog: the whole sequence needs well under 10000 cycles
    initial begin
        #1000000;
        mismatches++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude;
    end
endmodule // testbench
`default_nettype wire
